// ===== rtl/ibus_pkg.sv
package ibus_pkg;

   // region decode codes
   localparam logic [1:0] REGION_EMPTY = 2'h0;
   localparam logic [1:0] REGION_MEM = 2'h1;
   localparam logic [1:0] REGION_PERIPH = 2'h2;

   // default address windows, 16-bit address space
   localparam logic [15:0] ROM_BASE = 16'h0000;
   // the gap between the rom top and the peripheral window is empty
   localparam logic [15:0] ROM_LAST = 16'hDFFF;
   localparam logic [15:0] PERIPH_BASE = 16'hF000;
   localparam logic [15:0] PERIPH_LAST = 16'hF7FF;
   localparam logic [15:0] RAM_BASE = 16'hF780;
   localparam logic [15:0] RAM_LAST = 16'hFF7F;
   localparam logic [15:0] IO2_BASE = 16'hFF80;
   localparam logic [15:0] IO2_LAST = 16'hFFFF;

   // bus cycle lengths in states
   localparam logic [1:0] MEM_STATES = 2'h2;
   localparam logic [1:0] PERIPH_FAST_STATES = 2'h2;
   localparam logic [1:0] PERIPH_SLOW_STATES = 2'h3;

   // filler returned for undefined data
   localparam logic [7:0] UNDEF_BYTE = 8'hFF;
   localparam logic [15:0] UNDEF_WORD = 16'hFFFF;

   // cpu-level states and modes
   typedef enum logic [1:0] {
      CPU_RESET, CPU_EXEC, CPU_HALT, CPU_EXCEPT
   } cpu_state_e;
   typedef enum logic [1:0] {
      EXEC_HIGH, EXEC_MEDIUM, EXEC_SUB
   } exec_mode_e;
   typedef enum logic [1:0] {
      HALT_SLEEP, HALT_STANDBY, HALT_WATCH, HALT_SUBSLEEP
   } halt_mode_e;

   // bit manipulation operations
   typedef enum logic [2:0] {
      BIT_NONE, BIT_SET, BIT_CLEAR, BIT_INVERT, BIT_STORE, BIT_INV_STORE
   } bit_op_e;

   // cpu request
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic write;
      logic word;
      bit_op_e bit_op;
      logic [2:0] bit_sel;
      logic bit_val;
   } cpu_req_s;

   // internal bus toward memory and peripherals
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic write;
      logic word;
      logic mem_sel;
      logic periph_sel;
   } ibus_req_s;

endpackage

// ===== rtl/cpu_internal_bus_access.sv
// What this block does
// - one state is one rising edge of the active clock
// - every internal bus cycle lasts two or three states
// - on-chip ram and rom accesses finish in exactly two states
// - memory path is 16 bits, byte or word transfers
// - peripheral accesses take two or three states per cycle
// - peripheral path is 8 bits, byte transfers only
// - word write to peripherals stores upper byte, drops lower byte
// - word read from peripherals fills upper byte, lower byte undefined
// - write to an empty area stores nothing
// - read from an empty area returns an undefined value
// - four cpu states: reset, execution, halt, exception handling
// - active modes use system clock, subactive uses subclock
// - halt state has sleep, standby, watch and subsleep modes
// - exception handling is transient, entered on reset or interrupt
// - interrupt entry pushes program counter and condition code register
// - bit instructions read a byte, modify a bit, write it back
// - shared counter/load address reads counter, writes load register
`timescale 1ns/10ps
`default_nettype none
module cpu_internal_bus_access
(
   // clocks and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // clock selection and power state control
   input wire logic sub_clk_active_i,
   input wire ibus_pkg::exec_mode_e exec_mode_i,
   input wire logic halt_req_i,
   input wire ibus_pkg::halt_mode_e halt_mode_i,
   input wire logic wake_i,
   input wire logic irq_i,
   // cpu context for interrupt entry
   input wire logic [15:0] stack_pointer_i,
   input wire logic [15:0] program_counter_i,
   input wire logic [7:0] condition_code_reg_i,
   // cpu request and answer
   input wire logic req_valid_i,
   input wire ibus_pkg::cpu_req_s req_i,
   output logic req_ready_o,
   output logic resp_valid_o,
   output logic [15:0] rdata_o,
   // internal bus
   output ibus_pkg::ibus_req_s bus_o,
   output logic bus_strobe_o,
   output logic bus_last_o,
   output logic three_state_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic [7:0] periph_rdata_i,
   input wire logic periph_slow_i,
   // cpu state view
   output ibus_pkg::cpu_state_e cpu_state_o,
   output logic exec_sub_clock_o,
   output ibus_pkg::halt_mode_e halt_mode_o,
   output logic stacking_o
);
   import ibus_pkg::*;

   typedef enum logic [2:0] {
      SEQ_IDLE, SEQ_T1, SEQ_T2, SEQ_T3, SEQ_RMW_GAP, SEQ_PUSH
   } seq_e;

   // region decode, shared by the request and the bit-op write phase
   // anything outside rom, ram and peripherals decodes as an empty area
   function automatic logic [1:0] region_of(input logic [15:0] a);
      logic [1:0] r;
      r = REGION_EMPTY;
      if (a <= ROM_LAST)
         r = REGION_MEM;
      else if (a >= RAM_BASE && a <= RAM_LAST)
         r = REGION_MEM;
      else if ((a >= PERIPH_BASE && a < RAM_BASE) || a >= IO2_BASE)
         r = REGION_PERIPH;
      return r;
   endfunction

   // apply one bit operation to a byte read back from the bus
   // BIT_NONE passes the byte through untouched
   function automatic logic [7:0] bit_modify(input logic [7:0] d,
      input bit_op_e op, input logic [2:0] sel, input logic v);
      logic [7:0] m;
      m = d;
      unique case (op)
         BIT_SET: m[sel] = 1'b1;
         BIT_CLEAR: m[sel] = 1'b0;
         BIT_INVERT: m[sel] = ~d[sel];
         BIT_STORE: m[sel] = v;
         BIT_INV_STORE: m[sel] = ~v;
         default: m = d;
      endcase
      return m;
   endfunction

   // sequencer, cpu state and the captured request
   seq_e seq, next_seq;
   cpu_state_e cpu_state, next_cpu_state;
   cpu_req_s cur;
   halt_mode_e halt_mode;
   logic [1:0] region;
   logic rmw_write;
   logic slow;
   logic [1:0] push_idx;
   logic [15:0] rdata;
   logic resp_valid;
   logic sync_irq_a, sync_irq;
   logic sync_wake_a, sync_wake;
   // bit-op write-back byte and the interrupt stacking flag
   logic [7:0] modified_q;
   logic sync_irq_pending;

   // two-flop synchronisers for the asynchronous wake and interrupt lines
   // only the second flop is read, so a late edge cannot split the state
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync_irq_a <= 1'b0;
         sync_irq <= 1'b0;
         sync_wake_a <= 1'b0;
         sync_wake <= 1'b0;
      end
      else
      begin
         sync_irq_a <= irq_i;
         sync_irq <= sync_irq_a;
         sync_wake_a <= wake_i;
         sync_wake <= sync_wake_a;
      end
   end

   // request decode
   wire [1:0] req_region = region_of(req_i.addr);
   wire is_mem = (region == REGION_MEM);
   wire is_periph = (region == REGION_PERIPH);
   wire is_bitop = (cur.bit_op != BIT_NONE);
   wire take = req_ready_o && req_valid_i;
   wire in_access = (seq == SEQ_T1 || seq == SEQ_T2 || seq == SEQ_T3);
   wire last_state = (seq == SEQ_T2 && !(is_periph && slow)) ||
      (seq == SEQ_T3);
   wire read_phase_end = last_state && (!cur.write || is_bitop) && !rmw_write;

   // interrupt stacking: two words, each a two-state ram cycle, so the
   // push keeps the same memory timing as any other ram access
   wire push_second = push_idx[1]; // second word carries the flags
   wire push_write = push_idx[0]; // write state of each word
   wire push_done = (seq == SEQ_PUSH) && (push_idx == 2'h3);
   wire [15:0] push_addr = stack_pointer_i -
      {13'h0000, push_second, !push_second, 1'b0};

   // read data shaping per region
   wire [15:0] mem_rd = cur.word ? mem_rdata_i :
      {8'h00, cur.addr[0] ? mem_rdata_i[7:0] : mem_rdata_i[15:8]};
   wire [15:0] periph_rd = cur.word ? {periph_rdata_i, UNDEF_BYTE} :
      {8'h00, periph_rdata_i};
   wire [15:0] shaped_rd = is_mem ? mem_rd :
      is_periph ? periph_rd : UNDEF_WORD;
   wire [7:0] modified = bit_modify(shaped_rd[7:0], cur.bit_op,
      cur.bit_sel, cur.bit_val);

   // ready drops while a synchronised interrupt waits, so no access
   // starts that the exception entry would have to cut short
   assign req_ready_o = (seq == SEQ_IDLE) && (cpu_state == CPU_EXEC) &&
      !sync_irq;
   assign resp_valid_o = resp_valid;
   assign rdata_o = rdata;

   // cpu state view; the subclock itself is switched outside this block
   assign cpu_state_o = cpu_state;
   assign halt_mode_o = halt_mode;
   assign exec_sub_clock_o = (exec_mode_i == EXEC_SUB) &&
      sub_clk_active_i;
   assign stacking_o = (seq == SEQ_PUSH);
   assign three_state_o = in_access && is_periph && slow;

   // bus drive: empty area and peripheral word write get shaped here
   always_comb
   begin
      bus_o = '0;
      bus_strobe_o = 1'b0;
      bus_last_o = 1'b0;
      if (in_access)
      begin
         bus_o.addr = cur.addr;
         bus_o.write = (cur.write && !is_bitop) || rmw_write;
         bus_o.word = cur.word && is_mem && !is_bitop;
         bus_o.mem_sel = is_mem;
         // an empty area selects neither side, so a write is lost
         bus_o.periph_sel = is_periph;
         bus_strobe_o = (seq == SEQ_T1);
         bus_last_o = last_state;
         if (rmw_write)
            bus_o.wdata = {modified_q, modified_q};
         else if (is_periph)
            bus_o.wdata = {8'h00, cur.word ? cur.wdata[15:8] :
               cur.wdata[7:0]};
         else
            bus_o.wdata = cur.wdata;
      end
      else if (seq == SEQ_PUSH)
      begin
         // interrupt stacking goes to the on-chip ram only
         bus_o.addr = push_addr;
         bus_o.write = 1'b1;
         bus_o.word = 1'b1;
         bus_o.mem_sel = 1'b1;
         bus_o.wdata = push_second ?
            {condition_code_reg_i, condition_code_reg_i} :
            program_counter_i;
         bus_strobe_o = !push_write;
         bus_last_o = push_write;
      end
   end

   // cpu state transitions; exception handling ends once stacking is done, or at once after reset
   always_comb
   begin
      next_cpu_state = cpu_state;
      unique case (cpu_state)
         CPU_RESET: next_cpu_state = CPU_EXCEPT;
         CPU_EXEC:
            if (sync_irq && seq == SEQ_IDLE)
               next_cpu_state = CPU_EXCEPT;
            else if (halt_req_i && seq == SEQ_IDLE)
               next_cpu_state = CPU_HALT;
         // an interrupt ends any halt mode; wake returns to execution
         CPU_HALT:
            if (sync_irq)
               next_cpu_state = CPU_EXCEPT;
            else if (sync_wake)
               next_cpu_state = CPU_EXEC;
         CPU_EXCEPT:
            if (seq == SEQ_IDLE && !sync_irq_pending)
               next_cpu_state = CPU_EXEC;
      endcase
   end

   // sequencer: each state is one rising clock edge
   always_comb
   begin
      next_seq = seq;
      unique case (seq)
         SEQ_IDLE:
            if (cpu_state == CPU_EXCEPT && sync_irq_pending)
               next_seq = SEQ_PUSH;
            else if (take)
               next_seq = SEQ_T1;
         SEQ_T1: next_seq = SEQ_T2;
         SEQ_T2:
            if (is_periph && slow)
               next_seq = SEQ_T3;
            else if (read_phase_end && is_bitop)
               next_seq = SEQ_RMW_GAP;
            else
               next_seq = SEQ_IDLE;
         SEQ_T3:
            next_seq = (read_phase_end && is_bitop) ? SEQ_RMW_GAP : SEQ_IDLE;
         // one idle state between the read and the write phase
         SEQ_RMW_GAP: next_seq = SEQ_T1;
         SEQ_PUSH: next_seq = push_done ? SEQ_IDLE : SEQ_PUSH;
         default: next_seq = SEQ_IDLE;
      endcase
   end

   // sequencer and state registers
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         seq <= SEQ_IDLE;
         cpu_state <= CPU_RESET;
         sync_irq_pending <= 1'b0;
         halt_mode <= HALT_SLEEP;
      end
      else
      begin
         seq <= next_seq;
         cpu_state <= next_cpu_state;
         if (next_cpu_state == CPU_EXCEPT && cpu_state != CPU_EXCEPT)
            sync_irq_pending <= (cpu_state != CPU_RESET);
         else if (push_done)
            sync_irq_pending <= 1'b0;
         if (cpu_state == CPU_EXEC && halt_req_i)
            halt_mode <= halt_mode_i;
      end
   end

   // request capture, timing attribute and bit-op phase
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cur <= '0;
         region <= REGION_EMPTY;
         slow <= 1'b0;
         rmw_write <= 1'b0;
         modified_q <= 8'h00;
         push_idx <= 2'h0;
      end
      else
      begin
         if (take)
         begin
            cur <= req_i;
            region <= req_region;
            // one per-module attribute chooses peripheral timing
            slow <= (req_region == REGION_PERIPH) && periph_slow_i;
            rmw_write <= 1'b0;
         end
         else if (read_phase_end && is_bitop)
         begin
            // same address is written back; a shared counter/load slot
            // thus writes the load register from the live count
            modified_q <= modified;
            rmw_write <= 1'b1;
         end
         else if (last_state && rmw_write)
            rmw_write <= 1'b0;
         // the push count restarts whenever stacking is idle
         push_idx <= (seq == SEQ_PUSH) ? push_idx + 2'h1 : 2'h0;
      end
   end

   // answer: one state after the last state of the read or write phase, read data taken at the end of the read phase
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         resp_valid <= 1'b0;
         rdata <= 16'h0000;
      end
      else
      begin
         // a bit op answers once, after its write phase
         resp_valid <= last_state && (!is_bitop || rmw_write);
         if (read_phase_end)
            rdata <= shaped_rd;
      end
   end

endmodule
`default_nettype wire

// ===== verif/ibus_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ibus_sva
   import ibus_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // watched ports
   input wire logic req_ready_o,
   input wire logic resp_valid_o,
   input wire ibus_pkg::ibus_req_s bus_o,
   input wire logic bus_strobe_o,
   input wire logic bus_last_o,
   input wire logic three_state_o,
   input wire logic periph_slow_i,
   input wire ibus_pkg::cpu_state_e cpu_state_o,
   input wire logic exec_sub_clock_o,
   input wire ibus_pkg::exec_mode_e exec_mode_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // the two bus cycle shapes, counted from the strobe state
   sequence two_states;
      bus_strobe_o ##1 bus_last_o;
   endsequence
   sequence three_states;
      bus_strobe_o ##1 !bus_last_o ##1 bus_last_o;
   endsequence

   mem_two_state_a:
      assert property (bus_strobe_o && bus_o.mem_sel |-> two_states)
      else $error("memory cycle not two states");
   mem_not_slow_a:
      assert property (bus_strobe_o && bus_o.mem_sel |-> !three_state_o)
      else $error("memory cycle marked slow");
   periph_slow_a:
      assert property (bus_strobe_o && bus_o.periph_sel && three_state_o
         |-> three_states) else $error("slow cycle not three states");
   periph_fast_a:
      assert property (bus_strobe_o && bus_o.periph_sel && !three_state_o
         |-> two_states) else $error("fast cycle not two states");
   slow_attr_a:
      assert property (bus_strobe_o && bus_o.periph_sel
         |-> three_state_o == periph_slow_i)
      else $error("cycle length ignores module attribute");
   resp_end_a:
      assert property (resp_valid_o |-> $past(bus_last_o))
      else $error("answer without a last state");
   ready_exec_a:
      assert property (req_ready_o |-> cpu_state_o == CPU_EXEC)
      else $error("request taken outside execution");
   sub_clock_a:
      assert property (cpu_state_o == CPU_EXEC
         |-> exec_sub_clock_o == (exec_mode_i == EXEC_SUB))
      else $error("wrong clock for execution mode");
   except_short_a:
      assert property (cpu_state_o == CPU_EXCEPT
         |-> ##[1:24] cpu_state_o != CPU_EXCEPT)
      else $error("exception handling does not end");
endmodule
bind cpu_internal_bus_access ibus_sva u_sva (.clk_i, .arst_n_i,
   .req_ready_o, .resp_valid_o, .bus_o, .bus_strobe_o, .bus_last_o,
   .three_state_o, .periph_slow_i, .cpu_state_o, .exec_sub_clock_o,
   .exec_mode_i);
`default_nettype wire

// ===== verif/ibus_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ibus_mem_model
   import ibus_pkg::*;
(
   // clock
   input wire logic clk_i,
   // request address on offer while the bus is idle
   input wire logic [15:0] req_addr_i,
   // internal bus from the sequencer
   input wire ibus_pkg::ibus_req_s bus_i,
   input wire logic bus_last_i,
   // answers back
   output logic [15:0] mem_rdata_o,
   output logic [7:0] periph_rdata_o,
   output logic periph_slow_o
);
   // counter and load register share this address
   localparam logic [15:0] TMR_ADDR = 16'hF010;
   localparam logic [7:0] TMR_COUNT = 8'h31;
   logic [7:0] mem [0:65535];
   logic [7:0] load_reg;
   logic [7:0] junk = 8'hA5;
   wire [15:0] a = bus_i.addr;
   wire [15:0] ae = {a[15:1], 1'b0};
   // unselected lines toggle so stale data never looks valid
   // the timing attribute follows the address on offer, bus or request
   wire [15:0] sa = (bus_i.mem_sel || bus_i.periph_sel) ? a : req_addr_i;
   assign periph_slow_o = sa[4];
   assign mem_rdata_o = bus_i.mem_sel ? {mem[ae], mem[ae + 1]} :
      {junk, ~junk};
   assign periph_rdata_o = !bus_i.periph_sel ? junk :
      (a == TMR_ADDR) ? TMR_COUNT : mem[a];
   // writes land at the last state of the cycle
   always @(posedge clk_i)
   begin
      junk <= ~junk;
      if (bus_last_i && bus_i.write)
      begin
         if (bus_i.mem_sel && bus_i.word)
            {mem[ae], mem[ae + 1]} <= bus_i.wdata;
         else if (bus_i.periph_sel && a == TMR_ADDR)
            load_reg <= bus_i.wdata[7:0];
         else if (bus_i.mem_sel || bus_i.periph_sel)
            mem[a] <= bus_i.wdata[7:0];
      end
   end
endmodule
`default_nettype wire

// ===== verif/cpu_internal_bus_access_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_internal_bus_access_bench;
   import ibus_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic sub_clk_active_i = 1'b0;
   exec_mode_e exec_mode_i = EXEC_HIGH;
   logic halt_req_i = 1'b0;
   halt_mode_e halt_mode_i = HALT_SLEEP;
   logic wake_i = 1'b0;
   logic irq_i = 1'b0;
   logic [15:0] stack_pointer_i = 16'hF900;
   logic [15:0] program_counter_i = 16'h1357;
   logic [7:0] condition_code_reg_i = 8'h84;
   logic req_valid_i = 1'b0;
   cpu_req_s req_i = '0;
   logic req_ready_o, resp_valid_o, bus_strobe_o, bus_last_o;
   logic three_state_o, exec_sub_clock_o, stacking_o, periph_slow_i;
   logic [15:0] rdata_o, mem_rdata_i;
   logic [7:0] periph_rdata_i;
   ibus_req_s bus_o;
   cpu_state_e cpu_state_o;
   halt_mode_e halt_mode_o;
   int bad_count = 0;
   int check_count = 0;

   always #20 clk_i = ~clk_i;

   cpu_internal_bus_access DUT (.clk_i, .arst_n_i, .sub_clk_active_i,
      .exec_mode_i, .halt_req_i, .halt_mode_i, .wake_i, .irq_i,
      .stack_pointer_i, .program_counter_i, .condition_code_reg_i,
      .req_valid_i, .req_i, .req_ready_o, .resp_valid_o, .rdata_o, .bus_o,
      .bus_strobe_o, .bus_last_o, .three_state_o, .mem_rdata_i,
      .periph_rdata_i, .periph_slow_i, .cpu_state_o, .exec_sub_clock_o,
      .halt_mode_o, .stacking_o);
   ibus_mem_model mdl (.clk_i, .req_addr_i(req_i.addr), .bus_i(bus_o),
      .bus_last_i(bus_last_o),
      .mem_rdata_o(mem_rdata_i), .periph_rdata_o(periph_rdata_i),
      .periph_slow_o(periph_slow_i));

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // every wait is bounded; running out ends the run
   task automatic wait_hi(ref logic s, input string what);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (s !== 1'b1 && n < 200);
      if (s !== 1'b1)
      begin
         check(what, 16'h0, 16'h1);
         print_verdict();
      end
   endtask
   task automatic wait_state(cpu_state_e st);
      int n;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (cpu_state_o !== st && n < 200);
      if (cpu_state_o !== st)
      begin
         check("cpu state", {14'h0, cpu_state_o}, {14'h0, st});
         print_verdict();
      end
   endtask
   // request held until taken, answer caught in its one cycle
   task automatic access(logic [15:0] a, logic [15:0] d, logic wr,
      logic wd, bit_op_e op, output logic [15:0] q);
      @(posedge clk_i);
      req_i <= '{addr: a, wdata: d, write: wr, word: wd, bit_op: op,
         bit_sel: 3'h3, bit_val: 1'b0};
      req_valid_i <= 1'b1;
      wait_hi(req_ready_o, "ready");
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      wait_hi(resp_valid_o, "answer");
      q = rdata_o;
   endtask

   task automatic mem_and_periph();
      logic [15:0] q;
      access(16'hF800, 16'h1234, 1'b1, 1'b1, BIT_NONE, q);
      access(16'hF800, 16'h0000, 1'b0, 1'b1, BIT_NONE, q);
      check("mem word", q, 16'h1234);
      access(16'hF012, 16'h005A, 1'b1, 1'b0, BIT_NONE, q);
      access(16'hF012, 16'h0000, 1'b0, 1'b0, BIT_NONE, q);
      check("slow byte", {8'h00, q[7:0]}, 16'h005A);
      access(16'hF002, 16'hA55A, 1'b1, 1'b1, BIT_NONE, q);
      check("word to reg", {8'h00, mdl.mem[16'hF002]}, 16'h00A5);
      access(16'hF002, 16'h0000, 1'b0, 1'b1, BIT_NONE, q);
      check("word from reg", q, {8'hA5, UNDEF_BYTE});
      access(16'hE000, 16'h1234, 1'b1, 1'b1, BIT_NONE, q);
      check("empty store", {15'h0, mdl.mem[16'hE000] === 8'h12},
         16'h0000);
      access(16'hE000, 16'h0000, 1'b0, 1'b1, BIT_NONE, q);
      check("empty read", q, UNDEF_WORD);
   endtask
   // each op flips bit 3 of the byte left by the previous one
   task automatic bit_ops();
      bit_op_e ops [5] = '{BIT_SET, BIT_CLEAR, BIT_INVERT, BIT_STORE,
         BIT_INV_STORE};
      logic [15:0] q;
      access(16'hF003, 16'h0096, 1'b1, 1'b0, BIT_NONE, q);
      for (int i = 0; i < 5; i++)
      begin
         access(16'hF003, 16'h0000, 1'b0, 1'b0, ops[i], q);
         check("bit op", {8'h00, mdl.mem[16'hF003]},
            i[0] ? 16'h0096 : 16'h009E);
      end
      access(16'hF010, 16'h0000, 1'b0, 1'b0, BIT_SET, q);
      check("load reg", {8'h00, mdl.load_reg}, 16'h0039);
   endtask
   task automatic irq_push();
      @(posedge clk_i);
      irq_i <= 1'b1;
      wait_hi(stacking_o, "stacking");
      @(posedge clk_i);
      irq_i <= 1'b0;
      wait_state(CPU_EXEC);
      check("pushed counter", {mdl.mem[16'hF8FE], mdl.mem[16'hF8FF]},
         16'h1357);
      check("pushed flags", {15'h0, mdl.mem[16'hF8FC] === 8'h84 ||
         mdl.mem[16'hF8FD] === 8'h84}, 16'h0001);
   endtask
   task automatic halt_modes();
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk_i);
         halt_mode_i <= halt_mode_e'(m);
         halt_req_i <= 1'b1;
         wait_state(CPU_HALT);
         @(posedge clk_i);
         halt_req_i <= 1'b0;
         check("halt mode", {14'h0, halt_mode_o}, 16'(m));
         wake_i <= 1'b1;
         wait_state(CPU_EXEC);
         @(posedge clk_i);
         wake_i <= 1'b0;
      end
   endtask
   task automatic sub_mode();
      logic [15:0] q;
      @(posedge clk_i);
      exec_mode_i <= EXEC_SUB;
      sub_clk_active_i <= 1'b1;
      access(16'hF802, 16'hBEEF, 1'b1, 1'b1, BIT_NONE, q);
      check("sub clock", {15'h0, exec_sub_clock_o}, 16'h0001);
      @(posedge clk_i);
      exec_mode_i <= EXEC_HIGH;
      sub_clk_active_i <= 1'b0;
   endtask

   initial
   begin
      repeat (8) @(posedge clk_i);
      check("reset state", {14'h0, cpu_state_o}, 16'h0000);
      arst_n_i <= 1'b1;
      mem_and_periph();
      bit_ops();
      irq_push();
      halt_modes();
      sub_mode();
      print_verdict();
   end
endmodule
`default_nettype wire
